/* File: sim/thrm_master_model.sv */
// Bus master front end model: hands whole command and data bytes to the block.
// Assumes the testbench calls its tasks; outputs feed the block directly.
`timescale 1ns/100ps
module thrm_master_model
(
    // Clock
    input wire logic clk,
    // Byte stream
    output logic cmd_start,
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic overdrive_set
);
    initial
    begin
        cmd_start = 1'b0;
        byte_valid = 1'b0;
        byte_data = 8'h00;
        overdrive_set = 1'b0;
    end
    task put(input logic is_cmd, input logic [7:0] b);
        @(negedge clk);
        cmd_start = is_cmd;
        byte_valid = !is_cmd;
        byte_data = b;
    endtask
    // Released data shows the inverse, never a stale copy
    task idle();
        @(negedge clk);
        cmd_start = 1'b0;
        byte_valid = 1'b0;
        overdrive_set = 1'b0;
        byte_data = ~byte_data;
        @(negedge clk);
        @(negedge clk);
    endtask
    task write_pad(input logic [7:0] h, input logic [7:0] l, input logic [7:0] c);
        put(1'b1, thrm_pkg::CMD_WRITE_PAD);
        put(1'b0, h);
        put(1'b0, l);
        put(1'b0, c);
        idle();
    endtask
    task pair(input logic [7:0] c, input logic [7:0] t, input logic [7:0] i);
        put(1'b1, c);
        put(1'b0, t);
        put(1'b0, i);
        idle();
    endtask
    task od();
        @(negedge clk);
        overdrive_set = 1'b1;
        idle();
    endtask
endmodule

/* File: sim/thrm_regs_chain_tb.sv */
// Self-checking bench for the thermometer register and chain block.
// Assumes the master model drives bytes; this bench plays converter and pins.
`timescale 1ns/100ps
module thrm_regs_chain_tb;
    logic clk, rst_b, conv_start, conv_done, ext_b_low;
    logic cmd_start, byte_valid, overdrive_set;
    logic [7:0] byte_data, chain_answer, alarm_high_threshold, alarm_low_threshold;
    logic [7:0] conversion_configuration;
    logic [15:0] conv_result, temperature_readout, r, exp_t;
    logic pin_a_in, pin_b_in, pin_a_pulldown, pin_a_pullup, pin_b_pulldown;
    logic [1:0] conv_resolution;
    logic alarm_flag, alarm_search_join, cond_read_join, overdrive_flag, chain_answer_valid;
    logic [2:0] chain_state;
    logic [7:0] exp_q[$];
    logic [15:0] tv[6] = '{16'h0200, 16'h01f0, 16'h0190, 16'hff60, 16'hff58, 16'h0000};
    logic ta[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    int fail_count, checks, cycles;
    // Pin A has a resistor to supply; pin B is pulled low by us or the device
    assign pin_a_in = !pin_a_pulldown;
    assign pin_b_in = !(pin_b_pulldown || ext_b_low);
    thrm_master_model m (.clk(clk), .cmd_start(cmd_start), .byte_valid(byte_valid),
        .byte_data(byte_data), .overdrive_set(overdrive_set));
    thrm_regs_chain dut (.clk(clk), .rst_b(rst_b), .cmd_start(cmd_start),
        .byte_valid(byte_valid), .byte_data(byte_data), .overdrive_set(overdrive_set),
        .conv_start(conv_start), .conv_done(conv_done), .conv_result(conv_result),
        .pin_a_in(pin_a_in), .pin_b_in(pin_b_in), .pin_a_pulldown(pin_a_pulldown),
        .pin_a_pullup(pin_a_pullup), .pin_b_pulldown(pin_b_pulldown),
        .temperature_readout(temperature_readout), .alarm_high_threshold(alarm_high_threshold),
        .alarm_low_threshold(alarm_low_threshold), .conv_resolution(conv_resolution),
        .conversion_configuration(conversion_configuration), .alarm_flag(alarm_flag),
        .alarm_search_join(alarm_search_join), .cond_read_join(cond_read_join),
        .overdrive_flag(overdrive_flag), .chain_state(chain_state),
        .chain_answer_valid(chain_answer_valid), .chain_answer(chain_answer));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task print_verdict();
        if (exp_q.size() != 0)
            fail_count++;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Answers are one-cycle pulses, so sampled at every falling edge
    always @(negedge clk)
    begin
        if (rst_b === 1'b1 && chain_answer_valid === 1'b1)
        begin
            if (exp_q.size() > 0)
                check("chain_answer", {8'h00, chain_answer}, {8'h00, exp_q.pop_front()});
            else
                check("chain_answer_valid", 16'h0001, 16'h0000);
        end
    end
    // Run takes well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fail_count++;
            print_verdict();
        end
    end
    task conv_go();
        @(negedge clk);
        conv_start = 1'b1;
        @(negedge clk);
        conv_start = 1'b0;
    endtask
    task conv_end(input logic [15:0] v);
        conv_done = 1'b1;
        conv_result = v;
        @(negedge clk);
        conv_done = 1'b0;
        conv_result = ~v;
        @(negedge clk);
    endtask
    task chain(input logic [7:0] t, input logic [7:0] i, input logic [7:0] e);
        exp_q.push_back(e);
        m.pair(thrm_pkg::CMD_CHAIN, t, i);
    endtask
    task pins(input logic [2:0] e);
        check("pins", {pin_a_pulldown, pin_a_pullup, pin_b_pulldown}, e);
    endtask
    initial
    begin
        rst_b = 1'b0;
        conv_start = 1'b0;
        conv_done = 1'b0;
        conv_result = 16'h0000;
        ext_b_low = 1'b0;
        void'($urandom(32'h5c9e));
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        check("temperature", temperature_readout, 16'h0550);
        check("config", conversion_configuration, 8'h7f);
        check("chain_state", chain_state, 3'h1);
        pins(3'h0);
        check("overdrive", overdrive_flag, 1'b0);
        m.od();
        check("overdrive", overdrive_flag, 1'b1);
        $display("test reset done");
        exp_t = 16'h0550;
        for (int k = 0; k < 4; k++)
        begin
            r = 16'($urandom());
            m.write_pad(8'h20, 8'h05, {r[15], k[1:0], r[4:0]});
            check("config", conversion_configuration, {1'b0, k[1:0], 5'h1f});
            check("high", alarm_high_threshold, 8'h20);
            check("low", alarm_low_threshold, 8'h05);
            check("temperature", temperature_readout, exp_t);
            conv_go();
            conv_end(r);
            exp_t = r & (16'hffff << (3 - k));
            check("resolution", conv_resolution, k[1:0]);
            check("temperature", temperature_readout, exp_t);
        end
        conv_go();
        m.write_pad(8'h20, 8'h05, 8'h1f);
        conv_end(16'h0197);
        check("temperature", temperature_readout, 16'h0197);
        $display("test resolution done");
        m.write_pad(8'h20, 8'hf6, 8'h7f);
        for (int k = 0; k < 6; k++)
        begin
            conv_go();
            conv_end(tv[k]);
            check("alarm", alarm_flag, ta[k]);
            check("search", alarm_search_join, ta[k]);
            check("reading", temperature_readout, tv[k]);
        end
        $display("test alarm done");
        m.pair(thrm_pkg::CMD_PIO_WRITE, 8'hfe, 8'h01);
        pins(3'h4);
        m.pair(thrm_pkg::CMD_PIO_WRITE, 8'hfd, 8'h00);
        pins(3'h4);
        ext_b_low = 1'b1;
        repeat (3) @(negedge clk);
        check("cond_read", cond_read_join, 1'b0);
        chain(thrm_pkg::CHAIN_CODE_ON, 8'ha5, thrm_pkg::CONFIRM_BYTE);
        check("chain_state", chain_state, 3'h2);
        pins(3'h2);
        check("cond_read", cond_read_join, 1'b1);
        ext_b_low = 1'b0;
        repeat (3) @(negedge clk);
        check("cond_read", cond_read_join, 1'b0);
        m.pair(thrm_pkg::CMD_PIO_WRITE, 8'hfc, 8'h03);
        pins(3'h2);
        chain(8'h33, 8'hcc, thrm_pkg::REFUSE_BYTE);
        chain(thrm_pkg::CHAIN_CODE_DONE, 8'h00, thrm_pkg::REFUSE_BYTE);
        check("chain_state", chain_state, 3'h2);
        ext_b_low = 1'b1;
        chain(thrm_pkg::CHAIN_CODE_DONE, 8'h69, thrm_pkg::CONFIRM_BYTE);
        check("chain_state", chain_state, 3'h4);
        pins(3'h4);
        check("cond_read", cond_read_join, 1'b0);
        chain(thrm_pkg::CHAIN_CODE_OFF, 8'hc3, thrm_pkg::CONFIRM_BYTE);
        check("chain_state", chain_state, 3'h1);
        pins(3'h0);
        $display("test chain done");
        print_verdict();
    end
endmodule

/* File: verilog/thrm_pkg.sv */
// Package for the thermometer register and chain logic.
// Assumes a byte-level command front end decodes the bus in front of this block.
package thrm_pkg;
    localparam logic [7:0] CMD_WRITE_PAD = 8'h4e;
    localparam logic [7:0] CMD_CHAIN = 8'h99;
    localparam logic [7:0] CMD_PIO_WRITE = 8'ha5;
    localparam logic [7:0] CHAIN_CODE_OFF = 8'h3c;
    localparam logic [7:0] CHAIN_CODE_ON = 8'h5a;
    localparam logic [7:0] CHAIN_CODE_DONE = 8'h96;
    localparam logic [7:0] CONFIRM_BYTE = 8'haa;
    localparam logic [7:0] REFUSE_BYTE = 8'h00;
    localparam logic [2:0] ADDR_TEMP_LSB = 3'h0;
    localparam logic [2:0] ADDR_TEMP_MSB = 3'h1;
    localparam logic [2:0] ADDR_HIGH = 3'h2;
    localparam logic [2:0] ADDR_LOW = 3'h3;
    localparam logic [2:0] ADDR_CONFIG = 3'h4;
    localparam logic [15:0] TEMP_RESET = 16'h0550;
    localparam logic [7:0] HIGH_RESET = 8'h7f;
    localparam logic [7:0] LOW_RESET = 8'h80;
    localparam logic [1:0] RES_12BIT = 2'h3;
    localparam int RES_LSB_POS = 5;
    localparam logic [7:0] CONFIG_FIXED_ONE = 8'h1f;
    localparam logic [7:0] CONFIG_RES_MASK = 8'h60;
    localparam int TEMP_FRAC_BITS = 4;
    localparam int PIN_A_BIT = 0;
    localparam int PIN_B_BIT = 1;
    // Arbitrary value, stands for no real part
    localparam logic [7:0] FAMILY_DEFAULT = 8'h5b;

    typedef enum logic [2:0]
    {
        CHAIN_OFF = 3'h1,
        CHAIN_ON = 3'h2,
        CHAIN_DONE = 3'h4
    } thrm_chain_type;

    typedef enum logic [5:0]
    {
        CMD_IDLE = 6'h01,
        CMD_PAD = 6'h02,
        CMD_CH_TRUE = 6'h04,
        CMD_CH_INV = 6'h08,
        CMD_PIO_DATA = 6'h10,
        CMD_PIO_INV = 6'h20
    } thrm_cmd_type;
endpackage

/* File: verilog/thrm_regs_chain.sv */
// Register, alarm, chain and pin logic of a single-line-bus thermometer.
// Assumes a front end that delivers whole command and data bytes as pulses
// and a converter that delivers finished results as one-cycle pulses.
// What this block, its bus master and the board around it do
// RULE1 - Temperature as sixteen-bit signed, sixteenth degrees
// RULE2 - Low bits undefined below twelve-bit resolution
// RULE3 - Power-on temperature reads plus eighty-five
// RULE4 - Thresholds are eight-bit signed whole degrees
// RULE5 - Alarm sets at or beyond thresholds
// RULE6 - Alarm search participation follows alarm flag
// RULE7 - Alarm clears only strictly inside thresholds
// RULE8 - Config bit seven zero, low five one
// RULE9 - Config bits six, five select resolution
// RULE10 - Twelve-bit resolution is the default
// RULE11 - Pins open-drain with latch, released after reset
// RULE12 - Only pin A has chain pullup
// RULE13 - Chain state off, on, done via command
// RULE14 - Chain off: pins by access commands only
// RULE15 - Chain on: enable input, pullup, gated answer
// RULE16 - Chain done: pin A low, no answer
// RULE17 - Back to off releases both pins
// RULE18 - Master walks chain on, done, off
// RULE19 - First device enable held low externally
// RULE20 - Standard speed after reset, overdrive on command
// RULE21 - Scratchpad write fills high, low, config
// RULE22 - Master sends three bytes before reset
// RULE23 - Temperature changes only on conversion completion
// RULE24 - Chain codes 3c, 5a, 96, true then inverted
// RULE25 - Alarm compares whole-degree part, sign extended
// RULE26 - Resolution change applies from next conversion
`timescale 1ns/100ps
module thrm_regs_chain
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Byte stream from the bus front end
    input wire logic cmd_start,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic overdrive_set,
    // Converter handshake
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic [15:0] conv_result,
    // Pins
    input wire logic pin_a_in,
    input wire logic pin_b_in,
    output logic pin_a_pulldown,
    output logic pin_a_pullup,
    output logic pin_b_pulldown,
    // Readout and status
    output logic [15:0] temperature_readout,
    output logic [7:0] alarm_high_threshold,
    output logic [7:0] alarm_low_threshold,
    output logic [7:0] conversion_configuration,
    output logic [1:0] conv_resolution,
    output logic alarm_flag,
    output logic alarm_search_join,
    output logic cond_read_join,
    output logic overdrive_flag,
    output logic [2:0] chain_state,
    output logic chain_answer_valid,
    output logic [7:0] chain_answer
);
    typedef struct packed
    {
        logic [15:0] temp;
        logic [7:0] high;
        logic [7:0] low;
        logic [1:0] res;
        logic [1:0] res_active;
        logic alarm;
        logic od;
        thrm_pkg::thrm_chain_type chain;
        thrm_pkg::thrm_cmd_type cmd;
        logic [1:0] pad_idx;
        logic [7:0] held;
        logic [1:0] latch;
        logic pd_a;
        logic pu_a;
        logic pd_b;
        logic cond_join;
        logic ans_valid;
        logic [7:0] ans;
    } thrm_state_type;

    thrm_state_type st_ff;
    thrm_state_type nxt_st;

    localparam int TEMP_FRAC_BITS = thrm_pkg::TEMP_FRAC_BITS;
    localparam int RES_LSB_POS = thrm_pkg::RES_LSB_POS;
    localparam int PIN_A_BIT = thrm_pkg::PIN_A_BIT;
    localparam int PIN_B_BIT = thrm_pkg::PIN_B_BIT;

    // Whole degrees of a result, sign kept
    function automatic logic signed [11:0] thrm_whole(input logic [15:0] t);
        thrm_whole = $signed(t[15:TEMP_FRAC_BITS]);
    endfunction

    // Mask the bits that a reduced resolution leaves undefined
    function automatic logic [15:0] thrm_trim(input logic [15:0] t, input logic [1:0] r);
        logic [15:0] m;
        m = 16'hffff;
        case (r)
            2'h0: m = 16'hfff8;
            2'h1: m = 16'hfffc;
            2'h2: m = 16'hfffe;
            default: m = 16'hffff;
        endcase
        thrm_trim = t & m;
    endfunction

    logic signed [11:0] whole_deg;
    logic signed [11:0] high_ext;
    logic signed [11:0] low_ext;
    logic alarm_hit;
    logic alarm_inside;

    always_comb
    begin
        // RULE25 whole degree compare
        whole_deg = thrm_whole(conv_result);
        high_ext = {{4{st_ff.high[7]}}, st_ff.high};
        low_ext = {{4{st_ff.low[7]}}, st_ff.low};
        // RULE5 alarm at limits
        alarm_hit = (whole_deg >= high_ext) || (whole_deg <= low_ext);
        alarm_inside = (whole_deg < high_ext) && (whole_deg > low_ext);
    end

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ans_valid = 1'b0;
        // RULE20 overdrive only on command
        if (overdrive_set)
        begin
            nxt_st.od = 1'b1;
        end
        // RULE26 resolution latched at start
        if (conv_start)
        begin
            nxt_st.res_active = st_ff.res;
        end
        // RULE23 update on completion only
        if (conv_done)
        begin
            // RULE1 RULE2 signed readout trimmed
            nxt_st.temp = thrm_trim(conv_result, st_ff.res_active);
            // RULE7 clear strictly inside
            if (alarm_hit)
            begin
                nxt_st.alarm = 1'b1;
            end
            else if (alarm_inside)
            begin
                nxt_st.alarm = 1'b0;
            end
        end
        if (cmd_start)
        begin
            nxt_st.cmd = thrm_pkg::CMD_IDLE;
            case (byte_data)
                thrm_pkg::CMD_WRITE_PAD:
                begin
                    nxt_st.cmd = thrm_pkg::CMD_PAD;
                    nxt_st.pad_idx = 2'h0;
                end
                thrm_pkg::CMD_CHAIN: nxt_st.cmd = thrm_pkg::CMD_CH_TRUE;
                thrm_pkg::CMD_PIO_WRITE:
                begin
                    // Ignored while the chain owns the pins
                    if (st_ff.chain == thrm_pkg::CHAIN_OFF)
                    begin
                        nxt_st.cmd = thrm_pkg::CMD_PIO_DATA;
                    end
                end
                default: nxt_st.cmd = thrm_pkg::CMD_IDLE;
            endcase
        end
        else if (byte_valid)
        begin
            case (st_ff.cmd)
                thrm_pkg::CMD_PAD:
                begin
                    // RULE21 three bytes in order
                    case (st_ff.pad_idx)
                        2'h0: nxt_st.high = byte_data;
                        2'h1: nxt_st.low = byte_data;
                        // RULE9 RULE8 resolution field only
                        2'h2: nxt_st.res = byte_data[RES_LSB_POS +: 2];
                        default: nxt_st.high = st_ff.high;
                    endcase
                    nxt_st.pad_idx = 2'(st_ff.pad_idx + 2'h1);
                    if (st_ff.pad_idx == 2'h2)
                    begin
                        nxt_st.cmd = thrm_pkg::CMD_IDLE;
                    end
                end
                thrm_pkg::CMD_CH_TRUE:
                begin
                    nxt_st.held = byte_data;
                    nxt_st.cmd = thrm_pkg::CMD_CH_INV;
                end
                thrm_pkg::CMD_CH_INV:
                begin
                    nxt_st.cmd = thrm_pkg::CMD_IDLE;
                    nxt_st.ans_valid = 1'b1;
                    nxt_st.ans = thrm_pkg::REFUSE_BYTE;
                    // RULE24 valid codes, inverted copy
                    if (byte_data == ~st_ff.held)
                    begin
                        // RULE13 change via command
                        case (st_ff.held)
                            thrm_pkg::CHAIN_CODE_OFF:
                            begin
                                nxt_st.chain = thrm_pkg::CHAIN_OFF;
                                nxt_st.ans = thrm_pkg::CONFIRM_BYTE;
                            end
                            thrm_pkg::CHAIN_CODE_ON:
                            begin
                                nxt_st.chain = thrm_pkg::CHAIN_ON;
                                nxt_st.ans = thrm_pkg::CONFIRM_BYTE;
                            end
                            thrm_pkg::CHAIN_CODE_DONE:
                            begin
                                nxt_st.chain = thrm_pkg::CHAIN_DONE;
                                nxt_st.ans = thrm_pkg::CONFIRM_BYTE;
                            end
                            default: nxt_st.ans = thrm_pkg::REFUSE_BYTE;
                        endcase
                    end
                end
                thrm_pkg::CMD_PIO_DATA:
                begin
                    nxt_st.held = byte_data;
                    nxt_st.cmd = thrm_pkg::CMD_PIO_INV;
                end
                thrm_pkg::CMD_PIO_INV:
                begin
                    // RULE14 latch written only in chain off
                    if (byte_data == ~st_ff.held && st_ff.chain == thrm_pkg::CHAIN_OFF)
                    begin
                        nxt_st.latch = st_ff.held[1:0];
                    end
                    nxt_st.cmd = thrm_pkg::CMD_PIO_DATA;
                end
                default: nxt_st.cmd = thrm_pkg::CMD_IDLE;
            endcase
        end
        // RULE17 off restores latches released
        if (st_ff.chain != thrm_pkg::CHAIN_OFF && nxt_st.chain == thrm_pkg::CHAIN_OFF)
        begin
            nxt_st.latch = 2'h3;
        end
        // RULE11 RULE12 RULE15 RULE16 pin drive by chain state
        case (nxt_st.chain)
            thrm_pkg::CHAIN_ON:
            begin
                nxt_st.pd_a = 1'b0;
                nxt_st.pu_a = 1'b1;
                nxt_st.pd_b = 1'b0;
            end
            thrm_pkg::CHAIN_DONE:
            begin
                nxt_st.pd_a = 1'b1;
                nxt_st.pu_a = 1'b0;
                nxt_st.pd_b = 1'b0;
            end
            default:
            begin
                nxt_st.pd_a = ~nxt_st.latch[PIN_A_BIT];
                nxt_st.pu_a = 1'b0;
                nxt_st.pd_b = ~nxt_st.latch[PIN_B_BIT];
            end
        endcase
        // RULE15 answer only with enable low
        nxt_st.cond_join = (st_ff.chain == thrm_pkg::CHAIN_ON) && !pin_b_in;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            // RULE3 RULE10 RULE13 RULE20 power-on values
            st_ff <= '{temp: thrm_pkg::TEMP_RESET, high: thrm_pkg::HIGH_RESET,
                low: thrm_pkg::LOW_RESET, res: thrm_pkg::RES_12BIT,
                res_active: thrm_pkg::RES_12BIT, alarm: 1'b0, od: 1'b0,
                chain: thrm_pkg::CHAIN_OFF, cmd: thrm_pkg::CMD_IDLE, pad_idx: 2'h0, held: 8'h00,
                latch: 2'h3, pd_a: 1'b0, pu_a: 1'b0, pd_b: 1'b0,
                cond_join: 1'b0, ans_valid: 1'b0, ans: 8'h00};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state flops
    assign temperature_readout = st_ff.temp;
    // RULE4 thresholds stored raw
    assign alarm_high_threshold = st_ff.high;
    assign alarm_low_threshold = st_ff.low;
    // RULE8 fixed bits forced on read
    assign conversion_configuration = (({1'b0, st_ff.res, 5'h00} & thrm_pkg::CONFIG_RES_MASK)
        | thrm_pkg::CONFIG_FIXED_ONE);
    assign conv_resolution = st_ff.res_active;
    assign alarm_flag = st_ff.alarm;
    // RULE6 alarm search follows flag
    assign alarm_search_join = st_ff.alarm;
    assign cond_read_join = st_ff.cond_join;
    assign overdrive_flag = st_ff.od;
    assign chain_state = st_ff.chain;
    assign pin_a_pulldown = st_ff.pd_a;
    assign pin_a_pullup = st_ff.pu_a;
    assign pin_b_pulldown = st_ff.pd_b;
    assign chain_answer_valid = st_ff.ans_valid;
    assign chain_answer = st_ff.ans;

    // RULE23 readout steady between completions
    a_temp_steady: assert property (@(posedge clk) disable iff (!rst_b)
        !conv_done |=> $stable(temperature_readout))
        else $error("temperature changed without conversion");
    // RULE5 alarm set at limits
    a_alarm_set: assert property (@(posedge clk) disable iff (!rst_b)
        conv_done && alarm_hit |=> alarm_flag)
        else $error("alarm not set at threshold");
    // RULE7 alarm cleared inside
    a_alarm_clear: assert property (@(posedge clk) disable iff (!rst_b)
        conv_done && alarm_inside |=> !alarm_flag)
        else $error("alarm not cleared inside limits");
    // RULE16 done drives pin A low
    a_done_pull: assert property (@(posedge clk) disable iff (!rst_b)
        chain_state == thrm_pkg::CHAIN_DONE |-> pin_a_pulldown && !pin_a_pullup)
        else $error("done state without pin A low");
    // RULE12 pin A pullup only when on
    a_pullup_on: assert property (@(posedge clk) disable iff (!rst_b)
        pin_a_pullup |-> chain_state == thrm_pkg::CHAIN_ON)
        else $error("pullup outside chain on");
    // RULE15 conditional read gated
    a_cond_gate: assert property (@(posedge clk) disable iff (!rst_b)
        cond_read_join |-> $past(chain_state) == thrm_pkg::CHAIN_ON && !$past(pin_b_in))
        else $error("conditional read without enable");
    // RULE8 fixed config bits
    a_config_fixed: assert property (@(posedge clk) disable iff (!rst_b)
        conversion_configuration[7] == 1'b0 && conversion_configuration[4:0] == 5'h1f)
        else $error("config fixed bits wrong");
    // RULE20 overdrive needs command
    a_od_cause: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(overdrive_flag) |-> $past(overdrive_set))
        else $error("overdrive without command");
    // RULE24 chain change confirmed
    a_chain_ack: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(chain_state) |-> chain_answer_valid && chain_answer == 8'haa)
        else $error("chain change without confirm");
endmodule
